/* logic/icpd_pkg.sv */
// Constants and types for the interrupt controller page decoder.
// Assumes a 32-bit register data path and 64 KB register pages.
// How it works
// - Page number comes from address bits 16 upward.
// - Top of the page field follows the page count parameter, or the port address width when monolithic.
// - Non-monolithic: bits above ceil(log2(pages))+15 are ignored, so aliases hit.
// - Monolithic: two tie-offs give full page address of distributor and translation page.
// - Multi-view: two bits above the page field select the view.
// - Every page except reserved ones has read-only discovery registers from 0xFFD0.
// - Part code low 8 bits at 0xFFE0, upper 4 bits at 0xFFE4.
// - Part code differs for distributor, redistributor and translation pages.
// - Four pages per redistributor; its type register reports virtual interrupt support.
// - Multi-view: type register last flag reads set in views 1 to 3.
// - Redistributor type gives processor index; translation type says index targets.
// - Multichip: processor index upper bits come from die identifier tie-off.
// - Banked registers: Secure access hits Secure copy, Non-secure its own.
// - Interrupt group registers accept Secure accesses only.
// - Non-secure access to Secure-only register reads zero, writes ignored.
// - Unlisted or reserved distributor offsets read zero, writes ignored.
// - Reserved distributor access is logged with the bad access syndrome.
// - Cross-chip group control exists only multichip, both die flags zero.
// - Secure access control resets from tie-off; function control resets to zero.
// - Reset clears every register bit unless stated otherwise.
// - Write-only registers read an unspecified value (here zero).
// - Pages 0 to 3: distributor, messages, trace, performance monitor.
// - Security disable bit set lets Non-secure reach Secure registers.

package icpd_pkg;

  // ----------------------------------------
  // Page layout
  // ----------------------------------------
  localparam int PAGE_LSB   = 16;
  localparam int VIEW_BITS  = 2;
  localparam int FIXED_PGS  = 4;
  localparam int PGS_PER_IT = 4;
  localparam int PGS_PER_RD = 4;

  typedef enum logic [3:0] {
    PG_DIST, PG_MSI, PG_TRACE, PG_PMU, PG_ITS_CTL, PG_ITS_TRANS,
    PG_ITS_OTHER, PG_REDIST, PG_ALIAS, PG_RSVD
  } icpd_page_t;

  // ----------------------------------------
  // Offsets within a page
  // ----------------------------------------
  localparam logic [15:0] OFF_CTRL   = 16'h0000;
  localparam logic [15:0] OFF_TYPE   = 16'h0004;
  localparam logic [15:0] OFF_IIDR   = 16'h0008;
  localparam logic [15:0] OFF_TYPE2  = 16'h000C;
  localparam logic [15:0] OFF_FCTL   = 16'h0020;
  localparam logic [15:0] OFF_SAC    = 16'h0024;
  localparam logic [15:0] OFF_CCGRP  = 16'h0028;
  localparam logic [15:0] OFF_GRP_LO = 16'h0080;
  localparam logic [15:0] OFF_GRP_HI = 16'h00FC;
  localparam logic [15:0] OFF_DISC   = 16'hFFD0;
  localparam logic [15:0] OFF_PART_L = 16'hFFE0;
  localparam logic [15:0] OFF_PART_H = 16'hFFE4;
  localparam logic [15:0] OFF_RDTYPE = 16'h0008;
  localparam logic [15:0] OFF_TRTYPE = 16'h0008;
  localparam logic [15:0] OFF_TRREQ  = 16'h0040;

  // ----------------------------------------
  // Fields and values after reset
  // ----------------------------------------
  localparam int          CTRL_DS_BIT = 6;
  localparam int          RD_VLPI_BIT = 1;
  localparam int          RD_LAST_BIT = 4;
  localparam int          RD_PIDX_LSB = 8;
  localparam int          PIDX_W      = 16;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] TRTYPE_VAL  = 32'h0000_0001;
  localparam logic [7:0]  SYN_BAD_ACC = 8'h0E;

endpackage : icpd_pkg

/* logic/icpd_grp_mem.sv */
// Small register array for the interrupt group words.
// Assumes one write and one read port, read data one cycle late.
`timescale 1ns/1ns
module icpd_grp_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset,
  input  wire logic                     i_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
  input  wire logic [WIDTH-1:0]         i_wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx,
  output logic      [WIDTH-1:0]         o_rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // Cleared by reset so that no word needs software setup
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (i_wr_en) begin
      mem_r[i_wr_idx] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem_r[i_rd_idx];
    end
  end
endmodule : icpd_grp_mem

/* logic/icpd_page_sel.sv */
// Combinational page decoder from the bus address.
// Assumes page numbering with four pages per translation unit.
`timescale 1ns/1ns
module icpd_page_sel #(
  parameter int ADDR_W     = 32,
  parameter int PAGE_CNT   = 32,
  parameter int ITS_CNT    = 1,
  parameter int RD_CNT     = 2,
  parameter int RD_IDX_W   = 8,
  parameter bit MONOLITHIC = 1'b0,
  parameter bit MULTI_VIEW = 1'b0
) (
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [ADDR_W-17:0] i_dist_page,
  input  wire logic [ADDR_W-17:0] i_trans_page,
  output icpd_pkg::icpd_page_t    o_kind,
  output logic      [RD_IDX_W-1:0] o_rd_num,
  output logic      [1:0]         o_sub,
  output logic      [1:0]         o_view
);
  localparam int PG_BITS = (PAGE_CNT > 4) ? $clog2(PAGE_CNT) : 2;
  localparam int ITS_END = icpd_pkg::FIXED_PGS + icpd_pkg::PGS_PER_IT * ITS_CNT;
  localparam int RD_END  = ITS_END + icpd_pkg::PGS_PER_RD * RD_CNT;

  logic [PG_BITS-1:0] pg;
  int                 p;

  // Except in monolithic builds, higher bits never reach the decode, so aliases land on the same page
  assign pg     = i_addr[icpd_pkg::PAGE_LSB +: PG_BITS];
  assign o_view = MULTI_VIEW ? i_addr[icpd_pkg::PAGE_LSB + PG_BITS +: icpd_pkg::VIEW_BITS]
                             : 2'b00;
  assign o_sub  = pg[1:0];

  always_comb begin
    p        = int'(pg);
    o_kind   = icpd_pkg::PG_RSVD;
    o_rd_num = '0;
    if (MONOLITHIC) begin
      // Whole upper address compared, up to the port width
      if (i_addr[ADDR_W-1:icpd_pkg::PAGE_LSB] == i_dist_page) begin
        o_kind = icpd_pkg::PG_DIST;
      end else if (i_addr[ADDR_W-1:icpd_pkg::PAGE_LSB] == i_trans_page) begin
        o_kind = icpd_pkg::PG_ITS_TRANS;
      end
    end else if (p >= PAGE_CNT) begin
      o_kind = icpd_pkg::PG_RSVD;
    end else if (p < icpd_pkg::FIXED_PGS) begin
      case (pg[1:0])
        2'h0:    o_kind = icpd_pkg::PG_DIST;
        2'h1:    o_kind = icpd_pkg::PG_MSI;
        2'h2:    o_kind = icpd_pkg::PG_TRACE;
        default: o_kind = icpd_pkg::PG_PMU;
      endcase
    end else if (p < ITS_END) begin
      case (pg[1:0])
        2'h0:    o_kind = icpd_pkg::PG_ITS_CTL;
        2'h1:    o_kind = icpd_pkg::PG_ITS_TRANS;
        2'h2:    o_kind = icpd_pkg::PG_ITS_OTHER;
        default: o_kind = icpd_pkg::PG_RSVD;
      endcase
    end else if (p < RD_END) begin
      o_kind   = icpd_pkg::PG_REDIST;
      o_rd_num = RD_IDX_W'((p - ITS_END) / icpd_pkg::PGS_PER_RD);
    end else if (p == RD_END) begin
      o_kind = icpd_pkg::PG_ALIAS;
    end
  end
endmodule : icpd_page_sel

/* logic/icpd_top.sv */
// Register page decode and security banked register access.
// Assumes one request per cycle, answered exactly two cycles later.
`timescale 1ns/1ns
module icpd_top #(
  parameter int          ADDR_W      = 32,
  parameter int          PAGE_CNT    = 32,
  parameter int          ITS_CNT     = 1,
  parameter int          RD_CNT      = 2,
  parameter int          RD_IDX_W    = 8,
  parameter int          DIE_W       = 2,
  parameter bit          MONOLITHIC  = 1'b0,
  parameter bit          MULTI_VIEW  = 1'b0,
  parameter bit          MULTICHIP   = 1'b0,
  parameter bit          COH_CC      = 1'b0,
  parameter bit          UPPER_DIES  = 1'b0,
  // Identity values below are arbitrary
  parameter logic [11:0] PART_DIST   = 12'h7A1,
  parameter logic [11:0] PART_REDIST = 12'h7A2,
  parameter logic [11:0] PART_TRANS  = 12'h7A3,
  parameter logic [31:0] IIDR_VAL    = 32'h0000_0001,
  parameter logic [31:0] TYPE_VAL    = 32'h0000_0000,
  parameter logic [31:0] TYPE2_VAL   = 32'h0000_0000
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic              i_req_secure,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [31:0]       i_req_wdata,
  input  wire logic [ADDR_W-17:0] i_dist_page_tieoff,
  input  wire logic [ADDR_W-17:0] i_trans_page_tieoff,
  input  wire logic [31:0]       i_sac_reset_value,
  input  wire logic [DIE_W-1:0]  i_die_identifier_tieoff,
  output logic                   o_rsp_valid,
  output logic      [31:0]       o_rsp_rdata,
  output logic                   o_err_valid,
  output logic      [7:0]        o_err_syndrome,
  output logic      [ADDR_W-1:0] o_err_addr,
  output logic                   o_security_disable,
  output logic      [31:0]       o_function_control
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  localparam bit CC_PRESENT = MULTICHIP && !COH_CC && !UPPER_DIES;

  function automatic logic at_off(input logic [15:0] a, input logic [15:0] b);
    return a[15:2] == b[15:2];
  endfunction : at_off

  function automatic logic [11:0] part_of(input icpd_pkg::icpd_page_t k);
    case (k)
      icpd_pkg::PG_REDIST:    return PART_REDIST;
      icpd_pkg::PG_ITS_CTL,
      icpd_pkg::PG_ITS_TRANS,
      icpd_pkg::PG_ITS_OTHER: return PART_TRANS;
      icpd_pkg::PG_RSVD:      return 12'h000;
      default:                return PART_DIST;
    endcase
  endfunction : part_of

  icpd_pkg::icpd_page_t kind;
  logic [RD_IDX_W-1:0]  rd_num;
  logic [1:0]           sub;
  logic [1:0]           view;

  icpd_page_sel #(
    .ADDR_W     (ADDR_W),
    .PAGE_CNT   (PAGE_CNT),
    .ITS_CNT    (ITS_CNT),
    .RD_CNT     (RD_CNT),
    .RD_IDX_W   (RD_IDX_W),
    .MONOLITHIC (MONOLITHIC),
    .MULTI_VIEW (MULTI_VIEW)
  ) u_page_sel (
    .i_addr       (i_req_addr),
    .i_dist_page  (i_dist_page_tieoff),
    .i_trans_page (i_trans_page_tieoff),
    .o_kind       (kind),
    .o_rd_num     (rd_num),
    .o_sub        (sub),
    .o_view       (view)
  );

  logic [31:0] ctrl_s_r;
  logic [31:0] ctrl_ns_r;
  logic [31:0] fctl_r;
  logic [31:0] sac_r;
  logic [31:0] ccgrp_r;

  logic [15:0] off;
  logic        ds;
  logic        sec_ok;
  logic        dist_pg;
  logic        disc_hit;
  logic        grp_hit;
  logic        grp_ok;
  logic [4:0]  grp_idx;
  logic        dist_known;
  logic        dist_bad;
  logic        wr;
  logic        rd;

  assign off      = {i_req_addr[15:2], 2'b00};
  assign ds       = ctrl_s_r[icpd_pkg::CTRL_DS_BIT];
  // Security disabled opens Secure state to everybody
  assign sec_ok   = i_req_secure | ds;
  assign dist_pg  = (kind == icpd_pkg::PG_DIST) || (kind == icpd_pkg::PG_ALIAS);
  assign disc_hit = (off >= icpd_pkg::OFF_DISC) && (kind != icpd_pkg::PG_RSVD);
  assign grp_hit  = dist_pg && (off >= icpd_pkg::OFF_GRP_LO) && (off <= icpd_pkg::OFF_GRP_HI);
  assign grp_idx  = off[6:2];
  // Word 0 of the group block is reserved
  assign grp_ok   = grp_hit && (grp_idx != 5'h00) && sec_ok;
  assign wr       = i_req_valid && i_req_write;
  assign rd       = i_req_valid && !i_req_write;

  always_comb begin
    dist_known = at_off(off, icpd_pkg::OFF_CTRL) || at_off(off, icpd_pkg::OFF_TYPE)
              || at_off(off, icpd_pkg::OFF_IIDR) || at_off(off, icpd_pkg::OFF_TYPE2)
              || at_off(off, icpd_pkg::OFF_FCTL) || at_off(off, icpd_pkg::OFF_SAC)
              || (CC_PRESENT && at_off(off, icpd_pkg::OFF_CCGRP))
              || (grp_hit && (grp_idx != 5'h00)) || disc_hit;
    dist_bad   = dist_pg && !dist_known;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_s_r  <= icpd_pkg::RST_ZERO;
      ctrl_ns_r <= icpd_pkg::RST_ZERO;
    end else if (wr && dist_pg && at_off(off, icpd_pkg::OFF_CTRL)) begin
      if (sec_ok) begin
        ctrl_s_r <= i_req_wdata;
      end else begin
        ctrl_ns_r <= i_req_wdata;
      end
    end
  end

  // Function and access control are Secure-only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fctl_r <= icpd_pkg::RST_ZERO;
      sac_r  <= i_sac_reset_value;
    end else if (wr && dist_pg && sec_ok) begin
      if (at_off(off, icpd_pkg::OFF_FCTL)) begin
        fctl_r <= i_req_wdata;
      end
      if (at_off(off, icpd_pkg::OFF_SAC)) begin
        sac_r <= i_req_wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ccgrp_r <= icpd_pkg::RST_ZERO;
    end else if (CC_PRESENT && wr && dist_pg && sec_ok && at_off(off, icpd_pkg::OFF_CCGRP)) begin
      ccgrp_r <= i_req_wdata;
    end
  end

  logic [31:0] grp_rdata;

  icpd_grp_mem #(
    .DEPTH (32),
    .WIDTH (32)
  ) u_grp_mem (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr && grp_ok),
    .i_wr_idx  (grp_idx),
    .i_wr_data (i_req_wdata),
    .i_rd_idx  (grp_idx),
    .o_rd_data (grp_rdata)
  );

  // ----------------------------------------
  // Read values
  // ----------------------------------------
  localparam int PIDX_W_L = icpd_pkg::PIDX_W;
  logic [PIDX_W_L-1:0] pidx;
  logic [31:0]         rd_type;
  logic                rd_last;
  logic [31:0]         rd_val;
  logic                use_mem;
  logic [11:0]         part;

  // Die identifier must already be final when reset is released
  assign pidx    = MULTICHIP ? PIDX_W_L'({i_die_identifier_tieoff, rd_num})
                             : PIDX_W_L'(rd_num);
  assign rd_last = (rd_num == RD_IDX_W'(RD_CNT - 1))
                || (MULTI_VIEW && (view != 2'b00));
  assign part    = part_of(kind);

  always_comb begin
    rd_type                        = '0;
    rd_type[icpd_pkg::RD_VLPI_BIT] = 1'b1;
    rd_type[icpd_pkg::RD_LAST_BIT] = rd_last;
    rd_type[icpd_pkg::RD_PIDX_LSB +: icpd_pkg::PIDX_W] = pidx;
  end

  always_comb begin
    rd_val  = '0;
    use_mem = 1'b0;
    if (disc_hit) begin
      if (at_off(off, icpd_pkg::OFF_PART_L)) begin
        rd_val[7:0] = part[7:0];
      end else if (at_off(off, icpd_pkg::OFF_PART_H)) begin
        rd_val[3:0] = part[11:8];
      end
    end else begin
      case (kind)
        icpd_pkg::PG_DIST, icpd_pkg::PG_ALIAS: begin
          if (at_off(off, icpd_pkg::OFF_CTRL)) begin
            rd_val = sec_ok ? ctrl_s_r : ctrl_ns_r;
          end else if (at_off(off, icpd_pkg::OFF_TYPE)) begin
            rd_val = TYPE_VAL;
          end else if (at_off(off, icpd_pkg::OFF_IIDR)) begin
            rd_val = IIDR_VAL;
          end else if (at_off(off, icpd_pkg::OFF_TYPE2)) begin
            rd_val = TYPE2_VAL;
          end else if (at_off(off, icpd_pkg::OFF_FCTL)) begin
            rd_val = sec_ok ? fctl_r : '0;
          end else if (at_off(off, icpd_pkg::OFF_SAC)) begin
            rd_val = sec_ok ? sac_r : '0;
          end else if (CC_PRESENT && at_off(off, icpd_pkg::OFF_CCGRP)) begin
            rd_val = sec_ok ? ccgrp_r : '0;
          end else begin
            use_mem = grp_ok;
          end
        end
        icpd_pkg::PG_REDIST: begin
          if (sub == 2'b00 && at_off(off, icpd_pkg::OFF_RDTYPE)) begin
            rd_val = rd_type;
          end
        end
        icpd_pkg::PG_ITS_CTL: begin
          if (at_off(off, icpd_pkg::OFF_TRTYPE)) begin
            rd_val = icpd_pkg::TRTYPE_VAL;
          end
        end
        // The request word is write-only; its reads give zero
        icpd_pkg::PG_ITS_TRANS: rd_val = '0;
        default:                rd_val = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Response pipeline
  // ----------------------------------------
  // Two stages so the group array read lines up with the rest
  logic        s1_valid_r;
  logic        s1_mem_r;
  logic [31:0] s1_data_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s1_valid_r <= 1'b0;
      s1_mem_r   <= 1'b0;
      s1_data_r  <= '0;
    end else begin
      s1_valid_r <= i_req_valid;
      s1_mem_r   <= rd && use_mem;
      s1_data_r  <= rd ? rd_val : '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
    end else begin
      o_rsp_valid <= s1_valid_r;
      o_rsp_rdata <= s1_mem_r ? grp_rdata : s1_data_r;
    end
  end

  // ----------------------------------------
  // Error record and status
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_err_valid    <= 1'b0;
      o_err_syndrome <= '0;
      o_err_addr     <= '0;
    end else begin
      o_err_valid <= i_req_valid && dist_bad;
      if (i_req_valid && dist_bad) begin
        o_err_syndrome <= icpd_pkg::SYN_BAD_ACC;
        o_err_addr     <= i_req_addr;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_security_disable <= 1'b0;
      o_function_control <= '0;
    end else begin
      o_security_disable <= ds;
      o_function_control <= fctl_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_ns_grp_read;
    rd && grp_hit && !sec_ok;
  endsequence
  sequence s_ns_ctrl_write;
    wr && dist_pg && at_off(off, icpd_pkg::OFF_CTRL) && !sec_ok;
  endsequence
  sequence s_bad_read;
    rd && dist_bad;
  endsequence

  a_rsp_latency: assert property (i_req_valid |-> ##2 o_rsp_valid)
    else $error("response not two cycles after request");
  a_ns_group_raz: assert property (s_ns_grp_read |-> ##2 (o_rsp_rdata == 32'h0000_0000))
    else $error("non-secure group read not zero");
  a_bank_ns_copy: assert property (s_ns_ctrl_write |=>
      ($stable(ctrl_s_r) && ctrl_ns_r == $past(i_req_wdata)))
    else $error("non-secure control write hit wrong copy");
  a_reserved_raz: assert property (s_bad_read |-> ##2 (o_rsp_rdata == 32'h0000_0000))
    else $error("reserved offset read not zero");
  a_reserved_log: assert property ((i_req_valid && dist_bad) |=>
      (o_err_valid && o_err_syndrome == icpd_pkg::SYN_BAD_ACC
       && o_err_addr == $past(i_req_addr)))
    else $error("reserved access not logged");
  a_page_beyond: assert property ((rd && kind == icpd_pkg::PG_RSVD) |-> ##2
      (o_rsp_rdata == 32'h0000_0000))
    else $error("beyond page count not zero");
  a_part_low: assert property ((rd && dist_pg && at_off(off, icpd_pkg::OFF_PART_L)) |-> ##2
      (o_rsp_rdata == {24'h00_0000, PART_DIST[7:0]}))
    else $error("part code low wrong");
  a_part_high: assert property ((rd && kind == icpd_pkg::PG_REDIST
      && at_off(off, icpd_pkg::OFF_PART_H)) |-> ##2
      (o_rsp_rdata == {28'h000_0000, PART_REDIST[11:8]}))
    else $error("part code high wrong");
  a_view_last: assert property ((rd && kind == icpd_pkg::PG_REDIST && view != 2'b00
      && sub == 2'b00 && at_off(off, icpd_pkg::OFF_RDTYPE)) |-> ##2
      (o_rsp_rdata[icpd_pkg::RD_LAST_BIT] && o_rsp_rdata[icpd_pkg::RD_VLPI_BIT]))
    else $error("last flag clear in upper view");
  a_reset_vals: assert property ($fell(i_reset) |->
      (fctl_r == 32'h0000_0000 && sac_r == $past(i_sac_reset_value)))
    else $error("control reset value wrong");

endmodule : icpd_top

/* sim/icpd_mgr.sv */
// Interconnect manager model that issues register requests.
// Assumes the bench calls put and idle from one process.
`timescale 1ns/1ns
module icpd_mgr (
  input  wire logic        i_ref_clk,
  output logic             o_req_valid,
  output logic             o_req_write,
  output logic             o_req_secure,
  output logic [31:0]      o_req_addr,
  output logic [31:0]      o_req_wdata,
  output logic [1:0]       o_die
);
  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  initial begin
    o_req_valid  = 1'b0;
    o_req_write  = 1'b0;
    o_req_secure = 1'b0;
    o_req_addr   = 32'h0000_0000;
    o_req_wdata  = 32'h0000_0000;
    o_die        = 2'h1; // Fixed before reset ends
  end
  // Valid stays up between calls, so back-to-back needs no gap
  task automatic put(input logic w, input logic s, input logic [31:0] a, input logic [31:0] d);
    o_req_write  = w;
    o_req_secure = s;
    o_req_addr   = a;
    o_req_wdata  = d;
    o_req_valid  = 1'b1;
    @(posedge i_ref_clk);
    #1;
  endtask : put
  // Idle bus shows no stale request
  task automatic idle();
    o_req_valid = 1'b0;
    o_req_addr  = ~o_req_addr;
    o_req_wdata = ~o_req_wdata;
    @(posedge i_ref_clk);
    #1;
  endtask : idle
endmodule : icpd_mgr

/* sim/icpd_top_bench.sv */
// Self-checking bench for the page decoder, default and multi-view multichip builds.
// Assumes answers two cycles after each request, in order.
`timescale 1ns/1ns
module icpd_top_bench;
  localparam logic [31:0] SAC_RST = 32'h5A5A_0003;
  localparam logic [31:0] RSV [6] = '{32'h0000_0010, 32'h0000_001C, 32'h0000_0028,
                                      32'h0000_0080, 32'h0000_0100, 32'h0000_FFC0};
  logic        ref_clk, reset, req_valid, req_write, req_secure;
  logic        rsp_valid, err_valid, sec_dis, rsp2_valid;
  logic [31:0] rsp2_rdata;
  logic [31:0] req_addr, req_wdata, rsp_rdata, err_addr, fctl, seed, fc, v;
  logic [7:0]  err_syn;
  logic [1:0]  die;
  logic [31:0] exp_q [$];
  logic [31:0] exp2_q [$];
  logic [31:0] err_q [$];
  int          failures, total_checks, cycles;

  icpd_mgr mgr (.i_ref_clk(ref_clk), .o_req_valid(req_valid), .o_req_write(req_write),
    .o_req_secure(req_secure), .o_req_addr(req_addr), .o_req_wdata(req_wdata), .o_die(die));
  icpd_top dut (.i_ref_clk(ref_clk), .i_reset(reset), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_secure(req_secure), .i_req_addr(req_addr),
    .i_req_wdata(req_wdata), .i_dist_page_tieoff(16'h0000), .i_trans_page_tieoff(16'h0000),
    .i_sac_reset_value(SAC_RST), .i_die_identifier_tieoff(die), .o_rsp_valid(rsp_valid),
    .o_rsp_rdata(rsp_rdata), .o_err_valid(err_valid), .o_err_syndrome(err_syn),
    .o_err_addr(err_addr), .o_security_disable(sec_dis), .o_function_control(fctl));
  // Multi-view multichip build on the same requests; its error and status ports are left open and never checked
  icpd_top #(.MULTI_VIEW(1'b1), .MULTICHIP(1'b1)) dut_mc (.i_ref_clk(ref_clk), .i_reset(reset),
    .i_req_valid(req_valid), .i_req_write(req_write), .i_req_secure(req_secure), .i_req_addr(req_addr),
    .i_req_wdata(req_wdata), .i_dist_page_tieoff(16'h0000), .i_trans_page_tieoff(16'h0000),
    .i_sac_reset_value(SAC_RST), .i_die_identifier_tieoff(die), .o_rsp_valid(rsp2_valid),
    .o_rsp_rdata(rsp2_rdata), .o_err_valid(), .o_err_syndrome(), .o_err_addr(), .o_security_disable(),
    .o_function_control());

  // ----------------------------------------
  // Model and compare
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd2(input logic s, input logic [31:0] a, input logic [31:0] e, input logic [31:0] e2);
    exp_q.push_back(e);
    exp2_q.push_back(e2);
    mgr.put(1'b0, s, a, $random(seed));
  endtask : rd2
  task automatic rd(input logic s, input logic [31:0] a, input logic [31:0] e);
    rd2(s, a, e, e);
  endtask : rd
  task automatic wr(input logic s, input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back(32'h0000_0000);
    exp2_q.push_back(32'h0000_0000);
    mgr.put(1'b1, s, a, d);
  endtask : wr
  task automatic wrap_up();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (rsp_valid === 1'b1) check(rsp_rdata, exp_q.pop_front());
    if (rsp2_valid === 1'b1) check(rsp2_rdata, exp2_q.pop_front());
    if (err_valid === 1'b1) check(err_addr, err_q.pop_front());
    if (err_valid === 1'b1) check({24'h00_0000, err_syn}, 32'h0000_000E);
    if (cycles > 2000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 32'hc989_e542;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rd(1, 32'h0000_0020, 32'h0000_0000);
    rd(1, 32'h0000_0024, SAC_RST);
    rd(1, 32'h0000_0000, 32'h0000_0000);
    rd(1, 32'h0000_FFE0, 32'h0000_00A1);
    rd(0, 32'h0000_FFE4, 32'h0000_0007);
    rd(1, 32'h0004_FFE0, 32'h0000_00A3);
    rd(1, 32'h0008_FFE0, 32'h0000_00A2);
    rd2(1, 32'h0008_0008, 32'h0000_0002, 32'h0001_0002);
    rd2(1, 32'h000C_0008, 32'h0000_0112, 32'h0001_0112);
    rd2(1, 32'h0028_0008, 32'h0000_0002, 32'h0001_0012);
    rd(1, 32'h0005_0040, 32'h0000_0000);
    rd(1, 32'h0004_0008, 32'h0000_0001);
    fc = $random(seed);
    v = $random(seed) & 32'hFFFF_FFBF;
    wr(1, 32'h0000_0020, fc);
    rd(1, 32'h0000_0020, fc);
    wr(0, 32'h0000_0020, ~fc);
    rd(0, 32'h0000_0020, 32'h0000_0000);
    wr(1, 32'h0000_0000, v);
    wr(0, 32'h0000_0000, ~v);
    rd(1, 32'h0000_0000, v);
    rd(0, 32'h0000_0000, ~v);
    wr(1, 32'h0000_0084, v);
    rd(1, 32'h0000_0084, v);
    wr(0, 32'h0000_00FC, v);
    rd(1, 32'h0000_00FC, 32'h0000_0000);
    rd(0, 32'h0000_0084, 32'h0000_0000);
    foreach (RSV[i]) begin
      err_q.push_back(RSV[i]);
      err_q.push_back(RSV[i]);
      wr(1, RSV[i], v);
      rd2(1, RSV[i], 32'h0000_0000, (RSV[i] == 32'h0000_0028) ? v : 32'h0000_0000);
    end
    rd(1, 32'h0000_0020, fc);
    v = $random(seed);
    rd(1, {v[31:21], 21'h0_0020}, fc);
    rd(1, 32'h0010_0020, fc);
    rd(1, 32'h0011_0020, 32'h0000_0000);
    wr(1, 32'h0000_0000, 32'h0000_0040);
    rd(0, 32'h0000_0020, fc);
    repeat (4) mgr.idle();
    check({31'h0, sec_dis}, 32'h0000_0001);
    check(fctl, fc);
    check(exp_q.size(), 32'h0000_0000);
    check(exp2_q.size(), 32'h0000_0000);
    check(err_q.size(), 32'h0000_0000);
    wrap_up();
  end
endmodule : icpd_top_bench
